// ===== core/vdm_pkg.sv
// Shared types and constants of the voltage distortion monitor
package vdm_pkg;
    typedef logic [15:0] vdm_thd_t;
    typedef logic [13:0] vdm_thr_t;
    typedef logic [18:0] vdm_dly_t;

    typedef enum logic [2:0] {
        MODE_ON       = 3'h1,
        MODE_BLOCKED  = 3'h2,
        MODE_TEST     = 3'h3,
        MODE_TEST_BLK = 3'h4,
        MODE_OFF      = 3'h5
    } vdm_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'h0,
        ST_START   = 2'h1,
        ST_ALARM   = 2'h3,
        ST_BLOCKED = 2'h2
    } vdm_state_e;

    localparam logic [1:0] COND_NORMAL  = 2'h0;
    localparam logic [1:0] COND_START   = 2'h1;
    localparam logic [1:0] COND_ALARM   = 2'h2;
    localparam logic [1:0] COND_BLOCKED = 2'h3;

    typedef struct packed {
        vdm_thd_t amp;
        vdm_thd_t pow;
    } vdm_phase_s;

    // Event flags: 0 start on, 1 start off, 2 alarm on, 3 alarm off,
    // 4 blocked on, 5 blocked off
    typedef struct packed {
        logic [5:0]  flags;
        logic [31:0] stamp;
        vdm_thd_t    event_block_label;
        vdm_thd_t    thd2;
        vdm_thd_t    thd3;
        logic [2:0]  group;
    } vdm_event_s;

    // Log identity: bit 0 start on, bit 1 alarm on, bit 2 blocked on
    typedef struct packed {
        logic [31:0] stamp;
        logic [2:0]  ident;
        vdm_thd_t    event_block_label;
        vdm_thd_t    thd2;
        vdm_thd_t    thd3;
        logic [2:0]  group;
    } vdm_log_s;

    localparam int         LOG_DEPTH  = 12;
    localparam int         GROUPS     = 8;
    localparam logic [1:0] MAG_AMP    = 2'h1;
    localparam logic [1:0] MAG_POW    = 2'h2;

    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_EVMASK = 8'h08;
    localparam logic [7:0] OFS_LOGSEL = 8'h0C;
    localparam logic [7:0] OFS_LOGTS  = 8'h10;
    localparam logic [7:0] OFS_LOGA   = 8'h14;
    localparam logic [7:0] OFS_LOGB   = 8'h18;
    localparam logic [7:0] OFS_TIME   = 8'h1C;
    localparam logic [7:0] OFS_THR0   = 8'h20;
    localparam logic [7:0] OFS_DLY0   = 8'h40;

    localparam vdm_mode_e  RST_MODE   = MODE_ON;
    localparam logic [1:0] RST_MAG    = MAG_AMP;
    localparam logic [5:0] RST_EVMASK = 6'h3F;
    localparam vdm_thr_t   RST_THR    = 14'h03E8;
    localparam vdm_thr_t   THR_MIN    = 14'h000A;
    localparam vdm_thr_t   THR_MAX    = 14'h2710;
    localparam int         DLY_MS     = 10000;
    localparam int         STEP_MS    = 5;
    localparam vdm_dly_t   RST_DLY    = vdm_dly_t'(DLY_MS / STEP_MS);
    localparam vdm_dly_t   DLY_MAX    = 19'h5_7E40;
    localparam int         RESET_PCT  = 97;
    localparam int         CLK_HZ     = 20000000;
    localparam int         STAMP_MS   = 1;
    localparam int         MS_CYCLES  = CLK_HZ / 1000 * STAMP_MS;
endpackage : vdm_pkg

// ===== core/vdm_monitor.sv
// Three-phase voltage distortion alarm monitor with event log
//
// Contract
// - Mode setting takes codes 1 On to 5 Off, default On.
// - Magnitude select: 1 amplitude ratio, 2 power ratio; amplitude default.
// - Mode and magnitude are static, untouched by setting group changes.
// - Alarm enable 0 enables pick-up, 1 disables; disabled means no alarm.
// - One threshold 0.10..100.00 percent for all phases; any phase above picks up.
// - Pick-up releases only below 97 percent of the threshold.
// - Pick-up alone is not START; START only while blocking inactive.
// - Read-only behaviour field reports the effective mode code.
// - Read-only condition: 0 normal, 1 start, 2 alarm, 3 blocked.
// - Blocking sampled each program cycle; unblocked pick-up starts timing.
// - Blocking at pick-up gives BLOCKED and no further processing.
// - Blocking during START clears START and releases like drop-out.
// - Each blocking occurrence issues a time-stamped event with data.
// - Forcing mode lets a software switch drive the blocking input.
// - Definite delay 0..1800 s in 5 ms steps, default 10 s.
// - ON and OFF events for START, ALARM, BLOCKED, each maskable.
// - Each event carries a time stamp and process data.
// - Circular log keeps the 12 most recent entries.
// - ON events log time, identity, three phase values, setting group.
// - Phase measurements arrive every 5 ms for three phases.
// - Eight setting groups selected from one source, changeable live.
`timescale 1ns/1ns
module vdm_monitor
    import vdm_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
) (
    input  wire logic       clock_i,
    input  wire logic       resetn_i,
    input  wire logic       ce_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [31:0] rdata_o,
    input  wire vdm_phase_s phase_one_harmonic_input_i,
    input  wire vdm_phase_s phase_two_harmonic_input_i,
    input  wire vdm_phase_s phase_three_harmonic_input_i,
    input  wire logic       meas_valid_i,
    input  wire logic       blocking_i,
    input  wire logic [2:0] active_setting_group_i,
    output logic            start_o,
    output logic            alarm_o,
    output logic            blocked_o,
    output logic            event_valid_o,
    output vdm_event_s      event_o
);
    // Static settings, outside the group banks
    vdm_mode_e   mode;
    logic [1:0]  mag_sel;
    logic        alarm_dis;
    logic        force_en;
    logic        force_sw;
    logic [5:0]  ev_mask;
    logic [3:0]  log_sel;
    vdm_thr_t    thr_bank [GROUPS];
    vdm_dly_t    dly_bank [GROUPS];

    vdm_state_e  state;
    vdm_state_e  next_state;
    logic        pick;
    logic        next_pick;
    vdm_dly_t    cnt;
    vdm_dly_t    next_cnt;
    vdm_thd_t    thd_q [3];
    vdm_thd_t    sel_thd [3];
    logic [2:0]  over;
    logic [2:0]  under;
    logic [31:0] stamp;
    logic [31:0] ms_div;
    vdm_log_s    log_mem [LOG_DEPTH];
    logic [3:0]  log_wp;
    logic [3:0]  log_cnt;
    logic [3:0]  log_rd;
    logic [5:0]  flags;
    logic        blk_now;
    logic        eval;
    vdm_thr_t    thr;
    vdm_dly_t    dly;
    vdm_phase_s  phase [3];
    vdm_log_s    log_q;

    assign eval = ce_i & meas_valid_i;
    assign thr  = thr_bank[active_setting_group_i];
    assign dly  = dly_bank[active_setting_group_i];
    assign phase[0] = phase_one_harmonic_input_i;
    assign phase[1] = phase_two_harmonic_input_i;
    assign phase[2] = phase_three_harmonic_input_i;

    // Per-phase comparator with built-in release ratio
    genvar k;
    generate
        for (k = 0; k < 3; k++) begin : g_phase
            logic [23:0] meas_scaled;
            logic [23:0] rel_level;
            assign sel_thd[k] = (mag_sel == MAG_POW) ? phase[k].pow
                                                     : phase[k].amp;
            assign meas_scaled = 24'(sel_thd[k]) * 24'd100;
            assign rel_level   = 24'(thr) * 24'(RESET_PCT);
            assign over[k]  = sel_thd[k] > 16'(thr);
            assign under[k] = meas_scaled < rel_level;

            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    thd_q[k] <= 16'h0000;
                end else if (eval) begin
                    thd_q[k] <= sel_thd[k];
                end
            end
        end
    endgenerate

    // Effective blocking; forcing switch replaces the matrix input
    always_comb begin
        blk_now = force_en ? force_sw : blocking_i;
        if (mode == MODE_BLOCKED || mode == MODE_TEST_BLK) begin
            blk_now = 1'b1;
        end
    end

    // Pick-up with hysteresis: set above threshold, clear below 97 percent
    always_comb begin
        next_pick = pick;
        if (alarm_dis || mode == MODE_OFF) begin
            next_pick = 1'b0;
        end else if (|over) begin
            next_pick = 1'b1;
        end else if (&under) begin
            next_pick = 1'b0;
        end
    end

    // Monitoring sequence, evaluated once per program cycle
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        if (!next_pick) begin
            next_state = ST_IDLE;
            next_cnt   = '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    // Blocking sampled at the pick-up instant decides
                    next_state = blk_now ? ST_BLOCKED : ST_START;
                    next_cnt   = '0;
                end
                ST_START: begin
                    next_cnt = cnt + 19'h0_0001;
                    if (blk_now) begin
                        next_state = ST_BLOCKED;
                        next_cnt   = '0;
                    end else if (next_cnt >= dly) begin
                        next_state = ST_ALARM;
                    end
                end
                ST_ALARM: begin
                    if (blk_now) begin
                        next_state = ST_BLOCKED;
                        next_cnt   = '0;
                    end
                end
                ST_BLOCKED: begin
                    // Held until pick-up drops; later unblocking is ignored
                    next_state = ST_BLOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            pick  <= 1'b0;
            cnt   <= '0;
        end else if (eval) begin
            state <= next_state;
            pick  <= next_pick;
            cnt   <= next_cnt;
        end
    end

    assign start_o   = (state == ST_START) || (state == ST_ALARM);
    assign alarm_o   = (state == ST_ALARM);
    assign blocked_o = (state == ST_BLOCKED);

    // Transition flags, comparing outputs before and after the evaluation
    always_comb begin
        logic s_old;
        logic s_new;
        logic a_old;
        logic a_new;
        logic b_old;
        logic b_new;
        s_old = (state == ST_START) || (state == ST_ALARM);
        s_new = (next_state == ST_START) || (next_state == ST_ALARM);
        a_old = (state == ST_ALARM);
        a_new = (next_state == ST_ALARM);
        b_old = (state == ST_BLOCKED);
        b_new = (next_state == ST_BLOCKED);
        flags = {b_old & ~b_new, b_new & ~b_old,
                 a_old & ~a_new, a_new & ~a_old,
                 s_old & ~s_new, s_new & ~s_old};
    end

    // Millisecond time stamp
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ms_div <= 32'h0000_0000;
            stamp  <= 32'h0000_0000;
        end else if (ce_i) begin
            if (ms_div >= 32'(MS_DIV - 1)) begin
                ms_div <= 32'h0000_0000;
                stamp  <= stamp + 32'h0000_0001;
            end else begin
                ms_div <= ms_div + 32'h0000_0001;
            end
        end
    end

    // Event stream; masked-out directions never reach event_o
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            event_valid_o <= 1'b0;
            event_o       <= '0;
        end else if (ce_i) begin
            event_valid_o <= eval && |(flags & ev_mask);
            if (eval && |(flags & ev_mask)) begin
                event_o.flags <= flags & ev_mask;
                event_o.stamp <= stamp;
                event_o.event_block_label  <= sel_thd[0];
                event_o.thd2  <= sel_thd[1];
                event_o.thd3  <= sel_thd[2];
                event_o.group <= active_setting_group_i;
            end
        end
    end

    // Circular log of ON events, independent of the event mask
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            log_wp  <= 4'h0;
            log_cnt <= 4'h0;
        end else if (eval && (flags[0] | flags[2] | flags[4])) begin
            log_wp  <= (log_wp == 4'(LOG_DEPTH - 1)) ? 4'h0 : log_wp + 4'h1;
            if (log_cnt != 4'(LOG_DEPTH)) begin
                log_cnt <= log_cnt + 4'h1;
            end
        end
    end

    // Log array holds data only, so it needs no reset
    always_ff @(posedge clock_i) begin
        if (eval && (flags[0] | flags[2] | flags[4])) begin
            log_mem[log_wp] <= '{stamp: stamp,
                                 ident: {flags[4], flags[2], flags[0]},
                                 event_block_label: sel_thd[0],
                                 thd2: sel_thd[1],
                                 thd3: sel_thd[2],
                                 group: active_setting_group_i};
        end
    end

    // Index 0 of the read window is the newest entry
    always_comb begin
        logic [4:0] idx;
        idx = 5'(log_wp) + 5'(LOG_DEPTH) - 5'h01 - 5'(log_sel);
        if (idx >= 5'(LOG_DEPTH)) begin
            idx = idx - 5'(LOG_DEPTH);
        end
        log_rd = idx[3:0];
        log_q  = log_mem[log_rd];
    end

    // Static settings register
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode      <= RST_MODE;
            mag_sel   <= RST_MAG;
            alarm_dis <= 1'b0;
            force_en  <= 1'b0;
            force_sw  <= 1'b0;
        end else if (ce_i && wr_i && addr_i == OFS_CTRL) begin
            // Undefined codes are refused, keeping the old value
            if (wdata_i[2:0] >= 3'h1 && wdata_i[2:0] <= 3'h5) begin
                mode <= vdm_mode_e'(wdata_i[2:0]);
            end
            if (wdata_i[5:4] == MAG_AMP || wdata_i[5:4] == MAG_POW) begin
                mag_sel <= wdata_i[5:4];
            end
            alarm_dis <= wdata_i[8];
            force_en  <= wdata_i[12];
            force_sw  <= wdata_i[13];
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ev_mask <= RST_EVMASK;
            log_sel <= 4'h0;
        end else if (ce_i && wr_i) begin
            if (addr_i == OFS_EVMASK) begin
                ev_mask <= wdata_i[5:0];
            end
            if (addr_i == OFS_LOGSEL && wdata_i[3:0] < 4'(LOG_DEPTH)) begin
                log_sel <= wdata_i[3:0];
            end
        end
    end

    // Setting group banks; out-of-range values are refused
    generate
        for (k = 0; k < GROUPS; k++) begin : g_group
            always_ff @(posedge clock_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    thr_bank[k] <= RST_THR;
                    dly_bank[k] <= RST_DLY;
                end else if (ce_i && wr_i) begin
                    if (addr_i == OFS_THR0 + 8'(4 * k)
                            && wdata_i[31:14] == '0
                            && wdata_i[13:0] >= THR_MIN
                            && wdata_i[13:0] <= THR_MAX) begin
                        thr_bank[k] <= wdata_i[13:0];
                    end
                    if (addr_i == OFS_DLY0 + 8'(4 * k)
                            && wdata_i[31:19] == '0
                            && wdata_i[18:0] <= DLY_MAX) begin
                        dly_bank[k] <= wdata_i[18:0];
                    end
                end
            end
        end
    endgenerate

    // Read data, one cycle after the read strobe
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            rdata_o <= 32'h0000_0000;
            if (rd_i) begin
                if (addr_i == OFS_CTRL) begin
                    rdata_o <= {18'h0_0000, force_sw, force_en, 3'h0, alarm_dis,
                                2'h0, mag_sel, 1'b0, mode};
                end else if (addr_i == OFS_STATUS) begin
                    rdata_o <= {17'h0_0000, active_setting_group_i, 1'b0,
                                blocked_o, alarm_o, start_o, 2'h0,
                                state == ST_BLOCKED ? COND_BLOCKED :
                                state == ST_ALARM   ? COND_ALARM :
                                state == ST_START   ? COND_START : COND_NORMAL,
                                1'b0, mode};
                end else if (addr_i == OFS_EVMASK) begin
                    rdata_o <= {26'h000_0000, ev_mask};
                end else if (addr_i == OFS_LOGSEL) begin
                    rdata_o <= {20'h0_0000, log_cnt, 4'h0, log_sel};
                end else if (addr_i == OFS_LOGTS) begin
                    rdata_o <= log_q.stamp;
                end else if (addr_i == OFS_LOGA) begin
                    rdata_o <= {log_q.thd2, log_q.event_block_label};
                end else if (addr_i == OFS_LOGB) begin
                    rdata_o <= {9'h000, log_q.group, 1'b0, log_q.ident,
                                log_q.thd3};
                end else if (addr_i == OFS_TIME) begin
                    rdata_o <= stamp;
                end else if (addr_i >= OFS_THR0 && addr_i < OFS_DLY0) begin
                    rdata_o <= {18'h0_0000, thr_bank[addr_i[4:2]]};
                end else if (addr_i >= OFS_DLY0 && addr_i < 8'h60) begin
                    rdata_o <= {13'h0000, dly_bank[addr_i[4:2]]};
                end
            end
        end
    end
endmodule : vdm_monitor

// ===== bench/vdm_monitor_asserts.sv
// Concurrent checks on the monitor ports
`timescale 1ns/1ns
module vdm_monitor_asserts
    import vdm_pkg::*;
(
    input wire logic       clock_i,
    input wire logic       resetn_i,
    input wire logic       ce_i,
    input wire logic       rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic       meas_valid_i,
    input wire logic       blocking_i,
    input wire logic [2:0] active_setting_group_i,
    input wire logic       start_o,
    input wire logic       alarm_o,
    input wire logic       blocked_o,
    input wire logic       event_valid_o,
    input wire vdm_event_s event_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    sequence s_quiet;
        ce_i && !meas_valid_i;
    endsequence
    sequence s_eval;
        ce_i && meas_valid_i;
    endsequence

    a_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
        else $error("read data not cleared");
    a_quiet_hold: assert property (s_quiet |=>
        $stable({start_o, alarm_o, blocked_o}) && !event_valid_o)
        else $error("outputs moved without a strobe");
    a_start_strobe: assert property ($rose(start_o) |->
        $past(ce_i && meas_valid_i && !blocking_i)) else $error("start without clean strobe");
    a_blocked_excl: assert property (blocked_o |-> !start_o && !alarm_o)
        else $error("blocked beside start or alarm");
    a_alarm_start: assert property (alarm_o |-> start_o)
        else $error("alarm without start");
    a_event_flags: assert property (event_valid_o |-> event_o.flags != 6'h00)
        else $error("event with no flag");
    a_event_group: assert property (s_eval |=> !event_valid_o
        || event_o.group == $past(active_setting_group_i)) else $error("event group wrong");
    a_block_clears: assert property (s_eval and blocking_i && start_o |=>
        !start_o && !alarm_o) else $error("blocking left start up");
endmodule : vdm_monitor_asserts

bind vdm_monitor vdm_monitor_asserts u_vdm_monitor_asserts (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .meas_valid_i(meas_valid_i), .blocking_i(blocking_i),
    .active_setting_group_i(active_setting_group_i), .start_o(start_o), .alarm_o(alarm_o),
    .blocked_o(blocked_o), .event_valid_o(event_valid_o), .event_o(event_o));

// ===== bench/vdm_front_model.sv
// Measurement front end and blocking matrix model
`timescale 1ns/1ns
module vdm_front_model
    import vdm_pkg::*;
(
    input  wire logic  clock_i,
    input  wire logic  resetn_i,
    input  wire logic  fire_i,
    input  wire logic [1:0] ph_i,
    input  wire vdm_thd_t amp_i,
    input  wire vdm_thd_t pow_i,
    input  wire logic  blk_i,
    output vdm_phase_s ph1_o,
    output vdm_phase_s ph2_o,
    output vdm_phase_s ph3_o,
    output logic       meas_valid_o,
    output logic       blocking_o
);
    // Only the chosen phase carries distortion, the other two read zero
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meas_valid_o <= 1'b0;
            blocking_o   <= 1'b0;
            ph1_o        <= '0;
            ph2_o        <= '0;
            ph3_o        <= '0;
        end else begin
            meas_valid_o <= fire_i;
            if (fire_i) begin
                blocking_o <= blk_i;
                ph1_o      <= (ph_i == 2'h0) ? {amp_i, pow_i} : '0;
                ph2_o      <= (ph_i == 2'h1) ? {amp_i, pow_i} : '0;
                ph3_o      <= (ph_i == 2'h2) ? {amp_i, pow_i} : '0;
            end
        end
    end
endmodule : vdm_front_model

// ===== bench/vdm_monitor_test.sv
// Self-checking bench of the distortion monitor
`timescale 1ns/1ns
module vdm_monitor_test;
    import vdm_pkg::*;
    typedef struct packed {logic [15:0] amp; logic blk; logic [2:0] outs; logic [5:0] fl;} vdm_row_s;
    typedef struct packed {logic [15:0] ctrl; logic [15:0] amp; logic [15:0] pow;
        logic [2:0] outs; logic [15:0] stat;} vdm_mrow_s;
    localparam int LIMIT = 20000;
    logic clock_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, fire = 1'b0, blk = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
    logic [2:0]  grp = 3'h0;
    logic [1:0]  ph = 2'h0;
    vdm_thd_t    amp = 16'h0000, pow = 16'h0000;
    vdm_phase_s  ph1, ph2, ph3;
    logic        meas_valid, blocking, start_o, alarm_o, blocked_o, event_valid_o;
    logic        ce = 1'b1;
    vdm_event_s  event_o;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    vdm_row_s rows [11] = '{'{16'h03E8, 1'b0, 3'h0, 6'h00}, '{16'h03E9, 1'b0, 3'h4, 6'h01},
        '{16'h03CA, 1'b0, 3'h4, 6'h00}, '{16'h03CA, 1'b0, 3'h6, 6'h04},
        '{16'h03C9, 1'b0, 3'h0, 6'h0A}, '{16'h03E9, 1'b1, 3'h1, 6'h10},
        '{16'h03E9, 1'b0, 3'h1, 6'h00}, '{16'h01F4, 1'b0, 3'h0, 6'h20},
        '{16'h03E9, 1'b0, 3'h4, 6'h01}, '{16'h03E9, 1'b1, 3'h1, 6'h12},
        '{16'h01F4, 1'b0, 3'h0, 6'h20}};
    vdm_mrow_s modes [7] = '{'{16'h0015, 16'h07D0, 16'h0000, 3'h0, 16'h0005},
        '{16'h0111, 16'h07D0, 16'h0000, 3'h0, 16'h0001},
        '{16'h0012, 16'h07D0, 16'h0000, 3'h1, 16'h0432},
        '{16'h0014, 16'h07D0, 16'h0000, 3'h1, 16'h0434},
        '{16'h0013, 16'h07D0, 16'h0000, 3'h4, 16'h0113},
        '{16'h3011, 16'h07D0, 16'h0000, 3'h1, 16'h0431},
        '{16'h0021, 16'h0064, 16'h07D0, 3'h4, 16'h0111}};
    logic [39:0] regs [6] = '{{OFS_CTRL, 32'h0000_0011}, {OFS_STATUS, 32'h0000_0001},
        {OFS_EVMASK, 32'h0000_003F}, {OFS_THR0, 32'h0000_03E8},
        {OFS_DLY0, 32'h0000_07D0}, {8'hFC, 32'h0000_0000}};

    always #25 clock_i = ~clock_i;

    vdm_front_model u_vdm_front_model (.clock_i(clock_i), .resetn_i(resetn_i), .fire_i(fire),
        .ph_i(ph), .amp_i(amp), .pow_i(pow), .blk_i(blk), .ph1_o(ph1), .ph2_o(ph2),
        .ph3_o(ph3), .meas_valid_o(meas_valid), .blocking_o(blocking));
    // Short stamp divider keeps the run brief
    vdm_monitor #(.MS_DIV(4)) u_vdm_monitor (.clock_i(clock_i), .resetn_i(resetn_i),
        .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .phase_one_harmonic_input_i(ph1), .phase_two_harmonic_input_i(ph2),
        .phase_three_harmonic_input_i(ph3), .meas_valid_i(meas_valid), .blocking_i(blocking),
        .active_setting_group_i(grp), .start_o(start_o), .alarm_o(alarm_o),
        .blocked_o(blocked_o), .event_valid_o(event_valid_o), .event_o(event_o));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk("read data", exp, rdata_o);
    endtask : rd

    // Returns just after the evaluation edge, while the event pulse stands
    task automatic eval(input logic [1:0] p, input vdm_thd_t a, input vdm_thd_t w,
                        input logic b, input logic [2:0] outs);
        @(posedge clock_i);
        fire <= 1'b1;
        ph   <= p;
        amp  <= a;
        pow  <= w;
        blk  <= b;
        @(posedge clock_i);
        fire <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("outputs", {29'h0, outs}, {29'h0, start_o, alarm_o, blocked_o});
    endtask : eval

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        foreach (regs[i]) rd(regs[i][39:32], regs[i][31:0]);
        wr(OFS_CTRL, 32'h0000_0006);
        rd(OFS_CTRL, 32'h0000_0011);
        wr(OFS_THR0, 32'h0000_0009);
        rd(OFS_THR0, 32'h0000_03E8);
        wr(OFS_DLY0, 32'h0000_0002);
        foreach (rows[i]) begin
            eval(2'(i % 3), rows[i].amp, 16'h0000, rows[i].blk, rows[i].outs);
            chk("event flags", {26'h0, rows[i].fl},
                event_valid_o === 1'b1 ? {26'h0, event_o.flags} : 32'h0);
            // The driven phase must carry the value into its event field
            if (rows[i].fl != 6'h00) begin
                chk("event thd", {16'h0, rows[i].amp}, {16'h0,
                    i % 3 == 0 ? event_o.event_block_label : i % 3 == 1 ? event_o.thd2 : event_o.thd3});
            end
        end
        rd(OFS_LOGSEL, 32'h0000_0500);
        rd(OFS_LOGA, 32'h0000_03E9);
        rd(OFS_LOGB, 32'h0004_0000);
        for (int i = 0; i < 8; i++) begin
            eval(2'h1, 16'h07D0, 16'h0000, 1'b0, 3'h4);
            eval(2'h1, 16'h0000, 16'h0000, 1'b0, 3'h0);
        end
        rd(OFS_LOGSEL, 32'h0000_0C00);
        wr(OFS_EVMASK, 32'h0000_003D);
        eval(2'h0, 16'h07D0, 16'h0000, 1'b0, 3'h4);
        eval(2'h0, 16'h0000, 16'h0000, 1'b0, 3'h0);
        chk("masked event", 32'h0, {31'h0, event_valid_o});
        wr(OFS_EVMASK, 32'h0000_003F);
        foreach (modes[i]) begin
            wr(OFS_CTRL, {16'h0, modes[i].ctrl});
            eval(2'h2, modes[i].amp, modes[i].pow, 1'b0, modes[i].outs);
            rd(OFS_STATUS, {16'h0, modes[i].stat});
            eval(2'h2, 16'h0000, 16'h0000, 1'b0, 3'h0);
            wr(OFS_CTRL, 32'h0000_0011);
        end
        wr(OFS_THR0 + 8'h04, 32'h0000_0BB8);
        @(posedge clock_i);
        grp <= 3'h1;
        eval(2'h0, 16'h07D0, 16'h0000, 1'b0, 3'h0);
        eval(2'h0, 16'h0BB9, 16'h0000, 1'b0, 3'h4);
        rd(OFS_CTRL, 32'h0000_0011);
        rd(OFS_THR0, 32'h0000_03E8);
        // A strobe that would release START must be ignored while frozen
        @(posedge clock_i);
        ce <= 1'b0;
        eval(2'h0, 16'h0000, 16'h0000, 1'b0, 3'h4);
        @(posedge clock_i);
        ce       <= 1'b1;
        resetn_i <= 1'b0;
        @(posedge clock_i);
        resetn_i <= 1'b1;
        chk("reset outputs", 32'h0, {29'h0, start_o, alarm_o, blocked_o});
        rd(OFS_THR0 + 8'h04, 32'h0000_03E8);
        final_report();
    end
endmodule : vdm_monitor_test
